// *** verilog/lpddr2_refresh_mask_and_activate.v ***
// Refresh masks, training patterns, calibration decode and row-open tracking
`timescale 1ns/1ps
`default_nettype none
`include "lpddr2_refresh_mask_map.vh"

module lpddr2_refresh_mask_and_activate #(
  parameter [7:0] PATTERN_FIRST = 8'h55,
  parameter [7:0] PATTERN_SECOND = 8'h33,
  parameter CAL_SUPPORTED = 1,
  parameter INIT_UPDATES_INFO = 1,
  parameter EIGHT_BANK = 1,
  parameter [1:0] DENSITY = 2'h3
) (
  input wire core_clk,
  input wire rst_n,
  input wire clk_en,
  input wire link_ck,
  input wire cs_n,
  input wire [3:0] cmd,
  input wire [2:0] bank_addr,
  input wire [14:0] row_addr,
  input wire [7:0] mr_addr,
  input wire [7:0] mr_data,
  input wire cal_pin_to_ground,
  input wire cal_pin_to_supply,
  input wire self_refresh,
  input wire [2:0] refresh_bank,
  input wire [14:0] refresh_row,
  output reg [7:0] read_data,
  output reg read_valid,
  output reg cal_long,
  output reg cal_short,
  output reg cal_init,
  output reg cal_default,
  output reg [1:0] device_info,
  output reg soft_reset,
  output reg [7:0] bank_open,
  output reg [14:0] open_row,
  output reg rw_accept,
  output reg rw_refused,
  output reg refresh_skip
);

  ////////////////////////////////////////////////////////////////////////////////
  // Functions

  // Segment number from a row by density
  function [2:0] seg_of;
    input [14:0] row;
    input [1:0] dens;
    begin
      case (dens)
        `DENS_1G: seg_of = row[`SEG_LSB_1G +: 3];
        `DENS_8G: seg_of = row[`SEG_LSB_8G +: 3];
        default: seg_of = row[`SEG_LSB_MID +: 3];
      endcase
    end
  endfunction

  // One-hot bit for a bank or segment number
  function [7:0] onehot;
    input [2:0] n;
    begin
      onehot = 8'h01 << n;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  // Two flops per pin; the first stage feeds only the second. Each command
  // field is held for several core cycles around the link clock rise, so it
  // has settled in stage two by the time the rise shows there.
  reg ck_s1; // Link clock, first stage
  reg ck_s2; // Link clock, second stage
  reg ck_prev; // Last synced link clock level
  reg cs_n_s1; // Chip select, first stage
  reg cs_n_s; // Chip select, second stage
  reg [3:0] cmd_s1; // Command bits, first stage
  reg [3:0] cmd_s; // Command bits, second stage
  reg [2:0] ba_s1; // Bank address, first stage
  reg [2:0] ba_s; // Bank address, second stage
  reg [14:0] row_s1; // Row address, first stage
  reg [14:0] row_s; // Row address, second stage
  reg [7:0] ma_s1; // Register address, first stage
  reg [7:0] ma_s; // Register address, second stage
  reg [7:0] op_s1; // Register data, first stage
  reg [7:0] op_s; // Register data, second stage
  reg gnd_s1; // Ground strap, first stage
  reg gnd_s; // Ground strap, second stage
  reg sup_s1; // Supply strap, first stage
  reg sup_s; // Supply strap, second stage
  reg sr_s1; // Self-refresh flag, first stage
  reg sr_s; // Self-refresh flag, second stage
  reg [2:0] sr_bank_s1; // Refresh bank, first stage
  reg [2:0] sr_bank_s; // Refresh bank, second stage
  reg [14:0] sr_row_s1; // Refresh row, first stage
  reg [14:0] sr_row_s; // Refresh row, second stage

  // Synchroniser stages; select resets to its idle high level
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_prev <= 1'b0;
      cs_n_s1 <= 1'b1;
      cs_n_s <= 1'b1;
      cmd_s1 <= 4'h0;
      cmd_s <= 4'h0;
      ba_s1 <= 3'h0;
      ba_s <= 3'h0;
      row_s1 <= 15'h0;
      row_s <= 15'h0;
      ma_s1 <= 8'h00;
      ma_s <= 8'h00;
      op_s1 <= 8'h00;
      op_s <= 8'h00;
      gnd_s1 <= 1'b0;
      gnd_s <= 1'b0;
      sup_s1 <= 1'b0;
      sup_s <= 1'b0;
      sr_s1 <= 1'b0;
      sr_s <= 1'b0;
      sr_bank_s1 <= 3'h0;
      sr_bank_s <= 3'h0;
      sr_row_s1 <= 15'h0;
      sr_row_s <= 15'h0;
    end else if (clk_en) begin
      ck_s1 <= link_ck;
      ck_s2 <= ck_s1;
      ck_prev <= ck_s2;
      cs_n_s1 <= cs_n;
      cs_n_s <= cs_n_s1;
      cmd_s1 <= cmd;
      cmd_s <= cmd_s1;
      ba_s1 <= bank_addr;
      ba_s <= ba_s1;
      row_s1 <= row_addr;
      row_s <= row_s1;
      ma_s1 <= mr_addr;
      ma_s <= ma_s1;
      op_s1 <= mr_data;
      op_s <= op_s1;
      gnd_s1 <= cal_pin_to_ground;
      gnd_s <= gnd_s1;
      sup_s1 <= cal_pin_to_supply;
      sup_s <= sup_s1;
      sr_s1 <= self_refresh;
      sr_s <= sr_s1;
      sr_bank_s1 <= refresh_bank;
      sr_bank_s <= sr_bank_s1;
      sr_row_s1 <= refresh_row;
      sr_row_s <= sr_row_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command decode

  wire ck_rise = ck_s2 & ~ck_prev; // Rising edge of the link clock
  wire sel = ck_rise & ~cs_n_s;
  wire is_act = sel & ~cmd_s[0] & cmd_s[1];
  wire is_rw = sel & cmd_s[0] & ~cmd_s[1];
  wire is_pre = sel & (cmd_s == `CMD_PRE);
  wire is_mrw = sel & (cmd_s == `CMD_MRW);
  wire is_mrr = sel & (cmd_s == `CMD_MRR);
  wire reset_wr = is_mrw & (ma_s == `ADDR_SOFT_RESET);
  wire [7:0] bank_bit = onehot(ba_s);

  ////////////////////////////////////////////////////////////////////////////////
  // Straps caught after reset release

  reg strap_done; // Calibration pin straps captured
  reg [1:0] strap_wait; // Enabled edges seen since reset release
  reg pin_gnd; // Pin tied to ground through reference resistor
  reg pin_sup; // Pin tied to core supply

  // The pin connection is fixed after power-up; capture it once the
  // synchroniser has flushed its reset value, or calibration stays off
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_done <= 1'b0;
      strap_wait <= 2'h0;
      pin_gnd <= 1'b0;
      pin_sup <= 1'b0;
    end else if (clk_en && !strap_done) begin
      if (strap_wait == `STRAP_SETTLE) begin
        // Stage two now holds the pins, not its reset value
        strap_done <= 1'b1;
        pin_gnd <= gnd_s & ~sup_s;
        pin_sup <= sup_s;
      end else begin
        strap_wait <= strap_wait + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mode registers and calibration

  reg [7:0] bank_mask; // Write-only bank mask
  reg [7:0] seg_mask; // Write-only segment mask
  wire cal_ok = (CAL_SUPPORTED != 0) & pin_gnd & ~pin_sup;
  wire cal_wr = is_mrw & (ma_s == `ADDR_CAL);

  // Register writes, calibration pulses, reads and soft reset
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_mask <= `BANK_MASK_RESET;
      seg_mask <= `SEG_MASK_RESET;
      read_data <= 8'h00;
      read_valid <= 1'b0;
      cal_long <= 1'b0;
      cal_short <= 1'b0;
      cal_init <= 1'b0;
      cal_default <= 1'b0;
      device_info <= 2'h0;
      soft_reset <= 1'b0;
    end else if (clk_en) begin
      // Pulses last one cycle
      read_valid <= 1'b0;
      cal_long <= 1'b0;
      cal_short <= 1'b0;
      cal_init <= 1'b0;
      cal_default <= 1'b0;
      soft_reset <= 1'b0;
      if (reset_wr) begin
        // Data bits ignored; masks return to full refresh
        bank_mask <= `BANK_MASK_RESET;
        seg_mask <= `SEG_MASK_RESET;
        soft_reset <= 1'b1;
      end else if (is_mrw && ma_s == `ADDR_BANK_MASK) begin
        // Upper bits dropped on four-bank parts
        bank_mask <= (EIGHT_BANK != 0) ? op_s : {4'h0, op_s[3:0]};
      end else if (is_mrw && ma_s == `ADDR_SEG_MASK) begin
        seg_mask <= op_s;
      end
      // Calibration decode; reserved codes and disabled pin do nothing
      if (cal_wr && cal_ok) begin
        case (op_s)
          `CAL_LONG: cal_long <= 1'b1;
          `CAL_SHORT: cal_short <= 1'b1;
          `CAL_RESET: cal_default <= 1'b1;
          `CAL_INIT: begin
            cal_init <= 1'b1;
            if (INIT_UPDATES_INFO != 0) begin
              device_info <= {pin_sup, pin_gnd};
            end
          end
          default: cal_init <= 1'b0;
        endcase
      end
      // Mode register reads; unmapped addresses return zero
      if (is_mrr) begin
        read_valid <= 1'b1;
        case (ma_s)
          `ADDR_PATTERN_FIRST: read_data <= PATTERN_FIRST;
          `ADDR_PATTERN_SECOND: read_data <= PATTERN_SECOND;
          default: read_data <= 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bank state and row-to-column timing

  // Row-to-column delay in core cycles, cut to the counter's width on purpose
  localparam [31:0] RCD_FULL = `ROW_TO_COL_CYC;
  localparam [3:0] RCD_LOAD = RCD_FULL[3:0];
  reg [3:0] rcd_cnt [0:7]; // Cycles left before read or write is accepted
  integer i;

  // Track open banks and the delay since each was opened
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_open <= 8'h00;
      open_row <= 15'h0;
      rw_accept <= 1'b0;
      rw_refused <= 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
        rcd_cnt[i] <= 4'h0;
      end
    end else if (clk_en) begin
      rw_accept <= 1'b0;
      rw_refused <= 1'b0;
      // Count down every bank whose delay has not run out
      for (i = 0; i < 8; i = i + 1) begin
        if (rcd_cnt[i] != 4'h0) begin
          rcd_cnt[i] <= rcd_cnt[i] - 4'h1;
        end
      end
      if (reset_wr) begin
        bank_open <= 8'h00;
      end else if (is_act) begin
        // Open the addressed row; reopen without precharge is the controller's fault
        bank_open <= bank_open | bank_bit;
        open_row <= row_s;
        rcd_cnt[ba_s] <= RCD_LOAD;
      end else if (is_pre) begin
        bank_open <= bank_open & ~bank_bit;
      end else if (is_rw) begin
        // Accept only on an open bank whose delay has run out
        if ((bank_open & bank_bit) != 8'h00 && rcd_cnt[ba_s] == 4'h0) begin
          rw_accept <= 1'b1;
        end else begin
          rw_refused <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Partial-array self-refresh skip

  wire [7:0] sr_bank_bit = onehot(sr_bank_s);
  wire [7:0] sr_seg_bit = onehot(seg_of(sr_row_s, DENSITY));
  wire bank_hit = (bank_mask & sr_bank_bit) != 8'h00;
  wire seg_hit = (seg_mask & sr_seg_bit) != 8'h00;

  // Skip a location in self-refresh when either mask covers it
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      refresh_skip <= 1'b0;
    end else if (clk_en) begin
      refresh_skip <= sr_s & (bank_hit | seg_hit);
    end
  end

endmodule // lpddr2_refresh_mask_and_activate
`default_nettype wire

// *** verilog/lpddr2_refresh_mask_map.vh ***
// Constants for the refresh mask, training pattern and row-open command block
`ifndef LPDDR2_REFRESH_MASK_MAP_VH
`define LPDDR2_REFRESH_MASK_MAP_VH
// Mode register addresses
`define ADDR_CAL 8'h0a
`define ADDR_BANK_MASK 8'h10
`define ADDR_SEG_MASK 8'h11
`define ADDR_PATTERN_FIRST 8'h20
`define ADDR_PATTERN_SECOND 8'h28
`define ADDR_SOFT_RESET 8'h3f
// Reset values of the masks
`define BANK_MASK_RESET 8'h00
`define SEG_MASK_RESET 8'h00
// Calibration codes
`define CAL_INIT 8'hff
`define CAL_LONG 8'hab
`define CAL_SHORT 8'h56
`define CAL_RESET 8'hc3
// Command codes on cmd[3:0] (cmd[0] first)
`define CMD_MRW 4'h0
`define CMD_MRR 4'h8
`define CMD_PRE 4'hb
// Density codes
`define DENS_1G 2'h0
`define DENS_2G 2'h1
`define DENS_4G 2'h2
`define DENS_8G 2'h3
// Lowest row bit of the segment number, per density
`define SEG_LSB_1G 10
`define SEG_LSB_MID 11
`define SEG_LSB_8G 12
// Enabled edges after reset before the strap synchroniser holds the pins
`define STRAP_SETTLE 2'h2
// Row-to-column delay in ns and core clock period in ns
`define ROW_TO_COL_NS 18
`define CORE_PERIOD_NS 8
`define ROW_TO_COL_CYC ((`ROW_TO_COL_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS)
`endif

// *** verification/lpddr2_refresh_mask_and_activate_sva.sv ***
// Port assertions for the refresh mask and row-open block
`timescale 1ns/1ps
`default_nettype none
`include "lpddr2_refresh_mask_map.vh"
module lpddr2_refresh_mask_and_activate_sva #(
  parameter [7:0] PATTERN_FIRST = 8'h55,
  parameter [7:0] PATTERN_SECOND = 8'h33
) (
  input wire core_clk,
  input wire rst_n,
  input wire link_ck,
  input wire cs_n,
  input wire [3:0] cmd,
  input wire [2:0] bank_addr,
  input wire [14:0] row_addr,
  input wire [7:0] mr_addr,
  input wire [7:0] mr_data,
  input wire cal_pin_to_ground,
  input wire cal_pin_to_supply,
  input wire self_refresh,
  input wire [7:0] read_data,
  input wire read_valid,
  input wire cal_long,
  input wire cal_short,
  input wire cal_init,
  input wire cal_default,
  input wire soft_reset,
  input wire [7:0] bank_open,
  input wire [14:0] open_row,
  input wire rw_accept,
  input wire rw_refused,
  input wire refresh_skip
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Sampled link clock rise with the chip selected
  sequence frame;
    $rose(link_ck) && !cs_n;
  endsequence
  // Mode register read of a given address
  sequence mrr_at(a);
    frame ##0 (cmd == `CMD_MRR) && (mr_addr == a);
  endsequence
  AST_ACT_OPENS: assert property (frame ##0 (cmd[1:0] == 2'b10) |-> ##[1:6]
    (bank_open[bank_addr] && open_row == row_addr)) else $error("row open not taken");
  AST_PAT_FIRST: assert property (mrr_at(`ADDR_PATTERN_FIRST) |-> ##[1:6]
    (read_valid && read_data == PATTERN_FIRST)) else $error("first pattern wrong");
  AST_PAT_SECOND: assert property (mrr_at(`ADDR_PATTERN_SECOND) |-> ##[1:6]
    (read_valid && read_data == PATTERN_SECOND)) else $error("second pattern wrong");
  AST_CAL_INIT: assert property (frame ##0 (cmd == `CMD_MRW && mr_addr == `ADDR_CAL
    && mr_data == `CAL_INIT && cal_pin_to_ground && !cal_pin_to_supply) |-> ##[1:6] cal_init)
    else $error("init calibration missed");
  AST_CAL_ONE: assert property ($onehot0({cal_long, cal_short, cal_init, cal_default}))
    else $error("two calibration pulses");
  AST_CAL_STRAP: assert property ((cal_long || cal_short || cal_init) |->
    (cal_pin_to_ground && !cal_pin_to_supply)) else $error("calibration not ignored");
  AST_RW_PULSE: assert property ((rw_accept || rw_refused) |=> !(rw_accept || rw_refused))
    else $error("access answer too long");
  AST_RW_OPEN: assert property (rw_accept |-> bank_open[bank_addr])
    else $error("access accepted with no open bank");
  AST_SKIP_SR: assert property (refresh_skip |-> $past(self_refresh, 3))
    else $error("skip outside self refresh");
  AST_SOFT_CLEAR: assert property (soft_reset |-> ##[0:2] (bank_open == 8'h00))
    else $error("soft reset left banks open");
endmodule // lpddr2_refresh_mask_and_activate_sva
bind lpddr2_refresh_mask_and_activate lpddr2_refresh_mask_and_activate_sva #(
  .PATTERN_FIRST(PATTERN_FIRST), .PATTERN_SECOND(PATTERN_SECOND)) chk_inst (.*);
`default_nettype wire

// *** verification/lpddr2_ctrl_model.sv ***
// Memory controller model: one command frame per link clock rise
`timescale 1ns/1ps
`default_nettype none
module lpddr2_ctrl_model (
  output var logic link_ck,
  output var logic cs_n,
  output var logic [3:0] cmd,
  output var logic [2:0] bank_addr,
  output var logic [14:0] row_addr,
  output var logic [7:0] mr_addr,
  output var logic [7:0] mr_data
);
  // Idle: clock parked low, chip deselected
  initial begin
    link_ck = 1'b0;
    cs_n = 1'b1;
    {cmd, bank_addr, row_addr, mr_addr, mr_data} = '0;
  end
  // Frames are 125 ns long, far above row timings
  task automatic send(input logic [3:0] c, input logic [2:0] b, input logic [14:0] r, input logic [7:0] a, d);
    cs_n = 1'b0;
    {cmd, bank_addr, row_addr, mr_addr, mr_data} = {c, b, r, a, d};
    #20 link_ck = 1'b1;
    #62.5 link_ck = 1'b0;
    #20 cs_n = 1'b1;
    // Released lines show the inverse, never stale data
    {cmd, bank_addr, row_addr, mr_addr, mr_data} = ~{c, b, r, a, d};
    #22.5;
  endtask
endmodule // lpddr2_ctrl_model
`default_nettype wire

// *** verification/lpddr2_refresh_mask_and_activate_tb.sv ***
// Self-checking testbench for the refresh mask and row-open block
`timescale 1ns/1ps
`default_nettype none
`include "lpddr2_refresh_mask_map.vh"
module lpddr2_refresh_mask_and_activate_tb;
  logic core_clk, rst_n, clk_en, cal_pin_to_ground, cal_pin_to_supply, self_refresh;
  logic [2:0] refresh_bank;
  logic [14:0] refresh_row;
  wire link_ck, cs_n, read_valid, cal_long, cal_short, cal_init, cal_default;
  wire soft_reset, rw_accept, rw_refused, refresh_skip;
  wire [3:0] cmd;
  wire [2:0] bank_addr;
  wire [14:0] row_addr, open_row;
  wire [7:0] mr_addr, mr_data, read_data, bank_open;
  wire [1:0] device_info;
  logic [7:0] seen = 8'h00; // Pulses caught since the last command
  int num_errors = 0;
  int n_compared = 0;
  // Rows: cmd, address, data, expected pulses, expected read data
  logic [35:0] rows [8] = '{36'h8_20_00_80_55, 36'h8_28_00_80_33, 36'h8_05_00_80_00,
    36'h0_0a_ff_10_00, 36'h0_0a_ab_40_00, 36'h0_0a_56_20_00, 36'h0_0a_c3_08_00, 36'h0_0a_12_00_00};
  lpddr2_refresh_mask_and_activate lpddr2_refresh_mask_and_activate_inst (.*);
  lpddr2_ctrl_model lpddr2_ctrl_model_inst (.*);
  ////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // Pulse catcher
  always @(posedge core_clk) begin
    seen <= seen | {read_valid, cal_long, cal_short, cal_init, cal_default, soft_reset, rw_accept, rw_refused};
  end
  ////////////////////////////////////////////////////////////////
  task chk(input logic [15:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One command frame, pulse record cleared first
  task op(input logic [3:0] c, input logic [2:0] b, input logic [14:0] r, input logic [7:0] a, d);
    @(posedge core_clk);
    #1 seen = 8'h00;
    lpddr2_ctrl_model_inst.send(c, b, r, a, d);
  endtask
  // Present a self-refresh location and check the skip level
  task skip(input logic s, input logic [2:0] b, input logic [14:0] r, input logic e);
    @(posedge core_clk);
    #1 self_refresh = s;
    refresh_bank = b;
    refresh_row = r;
    repeat (5) @(posedge core_clk);
    #1 chk(16'(refresh_skip), 16'(e));
  endtask
  // Reset with the given straps, then let the strap capture settle
  task do_reset(input logic g, input logic s);
    rst_n = 1'b0;
    cal_pin_to_ground = g;
    cal_pin_to_supply = s;
    repeat (4) @(posedge core_clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge core_clk);
  endtask
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    #100us;
    num_errors++;
    end_sim();
  end
  // Main sequence; mapped and unmapped reads, accesses to an open and a closed bank
  initial begin
    clk_en = 1'b1;
    self_refresh = 1'b0;
    refresh_bank = 3'h0;
    refresh_row = 15'h0000;
    do_reset(1'b1, 1'b0);
    foreach (rows[i]) begin
      op(rows[i][35:32], 3'h0, 15'h0000, rows[i][31:24], rows[i][23:16]);
      chk(16'(seen), 16'(rows[i][15:8]));
      chk(16'(read_data), 16'(rows[i][7:0]));
    end
    chk(16'(device_info), 16'h0001);
    op(4'h2, 3'h2, 15'h5a5a, 8'h00, 8'h00);
    chk(16'(bank_open), 16'h0004);
    chk(16'(open_row), 16'h5a5a);
    op(4'h5, 3'h2, 15'h0000, 8'h00, 8'h00);
    chk(16'(seen), 16'h0002);
    op(4'h1, 3'h3, 15'h0000, 8'h00, 8'h00);
    chk(16'(seen), 16'h0001);
    // Clock enable low: a whole frame passes unseen
    @(posedge core_clk);
    #1 clk_en = 1'b0;
    op(`CMD_MRR, 3'h0, 15'h0000, 8'h05, 8'h00);
    chk(16'(seen), 16'h0000);
    @(posedge core_clk);
    #1 clk_en = 1'b1;
    op(`CMD_MRW, 3'h0, 15'h0000, `ADDR_BANK_MASK, 8'h0f);
    op(`CMD_MRW, 3'h0, 15'h0000, `ADDR_SEG_MASK, 8'h80);
    skip(1'b1, 3'h1, 15'h0000, 1'b1);
    skip(1'b1, 3'h5, 15'h0000, 1'b0);
    skip(1'b1, 3'h5, 15'h7000, 1'b1);
    skip(1'b1, 3'h5, 15'h6fff, 1'b0);
    skip(1'b0, 3'h1, 15'h7000, 1'b0);
    op(`CMD_MRW, 3'h0, 15'h0000, `ADDR_SOFT_RESET, 8'ha5);
    chk(16'(seen), 16'h0004);
    chk(16'(bank_open), 16'h0000);
    skip(1'b1, 3'h1, 15'h7000, 1'b0);
    skip(1'b0, 3'h0, 15'h0000, 1'b0);
    do_reset(1'b0, 1'b1);
    op(`CMD_MRW, 3'h0, 15'h0000, `ADDR_CAL, `CAL_LONG);
    chk(16'(seen), 16'h0000);
    op(`CMD_MRW, 3'h0, 15'h0000, `ADDR_CAL, `CAL_INIT);
    chk(16'({seen, device_info}), 16'h0000);
    end_sim();
  end
endmodule // lpddr2_refresh_mask_and_activate_tb
`default_nettype wire
